/* rtl/psc_pkg.sv */
// Package for the pseudo-static RAM host controller
// Assumes a 100 MHz system clock and an asynchronous SRAM-style device port
package psc_pkg;
	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 10; // Clock period in ns
	localparam int ACCESS_NS = 70; // Random access time, ns
	localparam int PAGE_NS = 20; // In-page access time, ns
	localparam int RECOVER_NS = 20; // Standby gap between accesses, ns
	localparam int IDLE_LIMIT_US = 1000; // Longest selected idle, 1 ms
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_CYC = (PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_LIMIT_CYC = IDLE_LIMIT_US * 1000 / CLK_PERIOD_NS;
	// ==========================================================
	// Address layout
	// ==========================================================
	localparam int ADDR_W = 22; // Device address width
	localparam int PAGE_W = 3; // Eight-word page
	localparam int MODE_LO = 19; // Mode field low bit
	localparam logic [21:0] TOP_ADDR = 22'h3F_FFFF; // Highest word
	localparam int PROG_STEPS = 6; // Accesses in mode program
	// ==========================================================
	// Power-down mode codes on address bits 20..19
	// ==========================================================
	typedef enum logic [1:0] {
		PSC_PD_LARGE = 2'b00, // 16M partial
		PSC_PD_MID = 2'b01, // 8M partial
		PSC_PD_SMALL = 2'b10, // 4M partial
		PSC_PD_SLEEP = 2'b11 // No retention, power-up default
	} psc_pd_mode_t;
	// ==========================================================
	// Device pin bundle
	// ==========================================================
	typedef struct packed {
		logic chip_select_n;
		logic power_chip_select;
		logic write_en_n;
		logic out_en_n;
		logic upper_lane_en_n;
		logic lower_lane_en_n;
		logic [21:0] addr;
	} psc_pins_t;
	// Host request bundle
	typedef struct packed {
		logic write;
		logic [1:0] lane_en;
		logic [21:0] addr;
		logic [15:0] wdata;
	} psc_req_t;
endpackage : psc_pkg

/* rtl/psc_ctrl.sv */
// Host-side controller for a pseudo-static RAM with an async SRAM port
// Assumes device pins synchronous to clk_i; data bus split into in/out/enable
`timescale 1ns/1ns
`default_nettype none

module psc_ctrl
	import psc_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic req_valid_i, // Ordinary access request
	output logic req_ready_o, // Request taken
	input wire psc_req_t req_i,
	output logic [15:0] rdata_o, // Read data
	output logic rdata_valid_o, // Read data pulse
	input wire logic prog_valid_i, // Program power-down mode
	input wire psc_pd_mode_t prog_mode_i,
	output logic prog_ready_o,
	input wire logic pd_req_i, // Level: stay in power-down
	output logic pd_active_o, // Device held in power-down
	output logic busy_o,
	output psc_pins_t pins_o,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic [1:0] dq_oe_o // Per lane: high while we drive
);
	// ==========================================================
	// State machine
	// ==========================================================
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, // Standby, both selects high
		ST_SETUP = 3'b001, // Address valid, strobes off
		ST_ACT = 3'b010, // Strobe active
		ST_RECOV = 3'b011, // Back in standby between accesses
		ST_PD = 3'b100 // Power-down
	} psc_state_t;

	psc_state_t state_q, state_d;
	logic [7:0] cnt_q, cnt_d; // Cycle counter
	logic [2:0] step_q, step_d; // Program step, 0 = ordinary
	logic [1:0] mode_q, mode_d; // Requested key mode
	logic [15:0] first_read_word_q, first_read_word_d; // Word of step 1
	psc_req_t cur_q, cur_d; // Current access
	logic page_hit_q, page_hit_d; // In-page follow-on read
	logic [21:0] last_raddr_q; // Last read address
	logic last_rvalid_q;
	logic [15:0] rdata_d;
	logic rvalid_d;

	// Build the access for a given program step
	function automatic psc_req_t prog_access(input logic [2:0] s, input logic [1:0] m, input logic [15:0] w);
		psc_req_t r;
		r.write = (s >= 3'd2) && (s <= 3'd5);
		r.lane_en = 2'b11;
		r.addr = TOP_ADDR;
		r.wdata = (s <= 3'd3) ? w : 16'h0000;
		if (s == 3'd6) begin
			r.addr[20:MODE_LO] = m;
		end
		return r;
	endfunction : prog_access

	// ==========================================================
	// Decode
	// ==========================================================
	wire logic in_prog = (step_q != 3'd0);
	wire logic start_ok = (state_q == ST_IDLE) && !pd_req_i;
	wire logic take_prog = start_ok && prog_valid_i;
	wire logic take_req = start_ok && !prog_valid_i && req_valid_i;
	wire logic rd_done = (state_q == ST_ACT) && !cur_q.write
		&& (cnt_q == 8'd0);
	wire logic same_page = last_rvalid_q && !req_i.write
		&& (req_i.addr[ADDR_W-1:PAGE_W] == last_raddr_q[ADDR_W-1:PAGE_W]);

	assign req_ready_o = take_req;
	assign prog_ready_o = take_prog;
	assign busy_o = (state_q != ST_IDLE);
	assign pd_active_o = (state_q == ST_PD);

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		step_d = step_q;
		mode_d = mode_q;
		first_read_word_d = first_read_word_q;
		cur_d = cur_q;
		page_hit_d = page_hit_q;
		rdata_d = rdata_o;
		rvalid_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (pd_req_i) begin
					state_d = ST_PD; // only from standby
				end else if (take_prog) begin
					step_d = 3'd1;
					mode_d = prog_mode_i; // retention mode asked for
					cur_d = prog_access(3'd1, prog_mode_i, first_read_word_q);
					page_hit_d = 1'b0;
					state_d = ST_SETUP;
				end else if (take_req) begin
					cur_d = req_i;
					page_hit_d = same_page;
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// One cycle of valid address before strobes
				cnt_d = page_hit_q ? 8'(PAGE_CYC - 1) : 8'(ACCESS_CYC - 1);
				state_d = ST_ACT;
			end
			ST_ACT: begin
				if (cnt_q != 8'd0) begin
					cnt_d = cnt_q - 8'd1;
				end else begin
					if (!cur_q.write) begin
						rdata_d = dq_i;
						rvalid_d = !in_prog;
						if (step_q == 3'd1) begin
							first_read_word_d = dq_i;
						end
					end
					cnt_d = 8'(RECOVER_CYC - 1);
					state_d = ST_RECOV; // standby between accesses
				end
			end
			ST_RECOV: begin
				if (cnt_q != 8'd0) begin
					cnt_d = cnt_q - 8'd1;
				end else if (in_prog && step_q != 3'(PROG_STEPS)) begin
					step_d = step_q + 3'd1;
					cur_d = prog_access(step_q + 3'd1, mode_q, first_read_word_q);
					state_d = ST_SETUP;
				end else begin
					step_d = 3'd0; // next sequence starts afresh
					state_d = ST_IDLE;
				end
			end
			ST_PD: begin
				if (!pd_req_i) begin
					state_d = ST_IDLE; // resume
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
			step_q <= 3'd0;
			mode_q <= PSC_PD_SLEEP;
			first_read_word_q <= 16'h0000;
			cur_q <= '0;
			page_hit_q <= 1'b0;
			rdata_o <= 16'h0000;
			rdata_valid_o <= 1'b0;
		end else if (clk_en_i) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			step_q <= step_d;
			mode_q <= mode_d;
			first_read_word_q <= first_read_word_d;
			cur_q <= cur_d;
			page_hit_q <= page_hit_d;
			rdata_o <= rdata_d;
			rdata_valid_o <= rvalid_d;
		end
	end

	// Page tracking; any write, program or power-down breaks the page
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_raddr_q <= 22'h00_0000;
			last_rvalid_q <= 1'b0;
		end else if (clk_en_i) begin
			if (rd_done && !in_prog) begin
				last_raddr_q <= cur_q.addr;
				last_rvalid_q <= 1'b1;
			end else if ((state_q == ST_ACT && cur_q.write) || state_q == ST_PD || in_prog) begin
				last_raddr_q <= last_raddr_q;
				last_rvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Pin drive
	// ==========================================================
	wire logic sel = (state_q == ST_SETUP) || (state_q == ST_ACT);
	wire logic act = (state_q == ST_ACT);
	wire logic no_lane = (cur_q.lane_en == 2'b00);
	always_comb begin
		pins_o.chip_select_n = !sel; // standby otherwise
		pins_o.power_chip_select = (state_q != ST_PD);
		pins_o.write_en_n = !(act && cur_q.write);
		pins_o.out_en_n = !(act && !cur_q.write && !no_lane);
		pins_o.upper_lane_en_n = !cur_q.lane_en[1];
		pins_o.lower_lane_en_n = !cur_q.lane_en[0];
		pins_o.addr = cur_q.addr;
	end
	assign dq_o = cur_q.wdata;
	assign dq_oe_o = (act && cur_q.write) ? cur_q.lane_en : 2'b00;

	// ==========================================================
	// Assertions
	// ==========================================================
	property p_read_strobe;
		@(posedge clk_i) disable iff (!arst_n_i)
		!pins_o.out_en_n |-> pins_o.write_en_n && !pins_o.chip_select_n && dq_oe_o == 2'b00;
	endproperty
	a_read_strobe: assert property (p_read_strobe) else $error("read strobe bad");
	property p_write_strobe;
		@(posedge clk_i) disable iff (!arst_n_i)
		!pins_o.write_en_n |-> pins_o.out_en_n && !pins_o.chip_select_n;
	endproperty
	a_write_strobe: assert property (p_write_strobe) else $error("write strobe bad");
	property p_no_lane;
		@(posedge clk_i) disable iff (!arst_n_i)
		(pins_o.upper_lane_en_n && pins_o.lower_lane_en_n) |-> pins_o.out_en_n;
	endproperty
	a_no_lane: assert property (p_no_lane) else $error("read without lanes");
	property p_idle_sel;
		@(posedge clk_i) disable iff (!arst_n_i)
		(state_q == ST_SETUP && clk_en_i) |=> state_q == ST_ACT;
	endproperty
	a_idle_sel: assert property (p_idle_sel) else $error("selected idle too long");
	property p_pd_entry;
		@(posedge clk_i) disable iff (!arst_n_i)
		$fell(pins_o.power_chip_select) |-> $past(pins_o.chip_select_n);
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down not from standby");
	property p_pd_hold;
		@(posedge clk_i) disable iff (!arst_n_i)
		!pins_o.power_chip_select |-> pins_o.chip_select_n && dq_oe_o == 2'b00;
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("activity in power-down");
	property p_gap;
		@(posedge clk_i) disable iff (!arst_n_i)
		(in_prog && $rose(pins_o.chip_select_n)) |-> pins_o.chip_select_n [*2];
	endproperty
	a_gap: assert property (p_gap) else $error("no standby between steps");
	property p_prog_addr;
		@(posedge clk_i) disable iff (!arst_n_i)
		(in_prog && step_q != 3'd6 && !pins_o.chip_select_n) |-> pins_o.addr == TOP_ADDR;
	endproperty
	a_prog_addr: assert property (p_prog_addr) else $error("program address wrong");
	property p_writeback;
		@(posedge clk_i) disable iff (!arst_n_i)
		(step_q inside {3'd2, 3'd3} && dq_oe_o != 2'b00) |-> dq_o == first_read_word_q;
	endproperty
	a_writeback: assert property (p_writeback) else $error("write-back data wrong");
	property p_key;
		@(posedge clk_i) disable iff (!arst_n_i)
		(step_q == 3'd6 && !pins_o.chip_select_n) |-> pins_o.addr[18:0] == 19'h7_FFFF
			&& pins_o.addr[21] && pins_o.write_en_n;
	endproperty
	a_key: assert property (p_key) else $error("key access wrong");
	c_read: cover property (@(posedge clk_i) disable iff (!arst_n_i) rdata_valid_o);
	c_prog: cover property (@(posedge clk_i) disable iff (!arst_n_i) step_q == 3'd6 && rd_done);
	c_pd: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(pd_active_o));
	c_page: cover property (@(posedge clk_i) disable iff (!arst_n_i) page_hit_q && rd_done);
endmodule : psc_ctrl

`default_nettype wire

/* verif/psc_mem_model.sv */
// Behavioural pseudo-static RAM seen through its asynchronous SRAM port
// Assumes pins from the host controller; lanes it does not drive show inverted data
`timescale 1ns/1ns
`default_nettype none
module psc_mem_model
	import psc_pkg::*;
#(
	parameter int DLY_NS = 30, // Read data delay, slow answer
	parameter int PG_NS = 10, // In-page read data delay
	parameter logic [15:0] FILL = 16'h5A5A // Word never written or lost
)(
	input wire psc_pins_t pins_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic [1:0] dq_oe_o
);
	// ==========================================================
	// State
	// ==========================================================
	logic [15:0] mem [int]; // Sparse array
	psc_pd_mode_t mode_q = PSC_PD_SLEEP; // Power-up default
	int step_q = 0; // Program sequence position
	int lim;
	int kq [$];
	logic act_q = 1'b0; // An access is under way
	logic rd_q;
	logic [21:0] a_q;
	logic [15:0] wd_q, w, rdat;
	logic [1:0] ln_q;
	logic [18:0] lp_q; // Page of the last access
	logic lpv_q = 1'b0; // A read page is open
	wire pg = lpv_q && (a_q[21:3] == lp_q); // In-page follow-on read
	wire sel = !pins_i.chip_select_n && pins_i.power_chip_select; // Else standby or power-down
	wire rd_en = sel && pins_i.write_en_n && !pins_i.out_en_n;
	wire [1:0] lanes = ~{pins_i.upper_lane_en_n, pins_i.lower_lane_en_n};
	// ==========================================================
	// Read path
	// ==========================================================
	// Stored word, or the fill pattern if never written or lost
	function automatic logic [15:0] fetch(input logic [21:0] ad);
		return mem.exists(int'(ad)) ? mem[int'(ad)] : FILL;
	endfunction : fetch
	// Only enabled lanes driven, none with both off
	assign dq_oe_o = rd_en ? lanes : 2'b00;
	// Undriven lanes show the inverse; in-page reads answer fast
	wire [15:0] drv = {dq_oe_o[1] ? rdat[15:8] : ~rdat[15:8], dq_oe_o[0] ? rdat[7:0] : ~rdat[7:0]};
	wire [15:0] slow_w, fast_w;
	assign #DLY_NS slow_w = drv;
	assign #PG_NS fast_w = drv;
	assign dq_o = pg ? fast_w : slow_w;
	// Remember the access while strobes are low
	always @* if (sel && (!pins_i.out_en_n || !pins_i.write_en_n)) begin
		act_q = 1'b1;
		a_q = pins_i.addr;
		rdat = fetch(pins_i.addr);
		rd_q = pins_i.write_en_n;
		wd_q = dq_i;
		ln_q = lanes;
	end
	// Commit writes and follow the program sequence at access end
	always @(posedge pins_i.chip_select_n) if (act_q) begin
		if (!rd_q && !(step_q >= 3 && step_q <= 4 && a_q == TOP_ADDR)) begin // Key writes carry no data
			w = rdat;
			if (ln_q[0]) w[7:0] = wd_q[7:0]; // Lane stores
			if (ln_q[1]) w[15:8] = wd_q[15:8];
			mem[int'(a_q)] = w;
		end
		case (step_q)
			0: step_q = (rd_q && a_q == TOP_ADDR) ? 1 : 0;
			1, 2, 3, 4: step_q = (!rd_q && a_q == TOP_ADDR) ? step_q + 1 : 0; // Cancel keeps mode
			default: begin
				if (rd_q && a_q[21] && &a_q[18:0]) mode_q = psc_pd_mode_t'(a_q[20:19]); // Key
				step_q = 0;
			end
		endcase
		lpv_q = rd_q; // Only a read leaves a page open
		lp_q = a_q[21:3];
		rdat = fetch(a_q);
		act_q = 1'b0;
	end
	// Drop what the mode does not retain on power-down
	always @(negedge pins_i.power_chip_select) begin
		lim = mode_q == PSC_PD_SMALL ? 32'h0003_FFFF : mode_q == PSC_PD_MID ? 32'h0007_FFFF :
			mode_q == PSC_PD_LARGE ? 32'h000F_FFFF : -1;
		foreach (mem[k]) if (k > lim) kq.push_back(k);
		foreach (kq[j]) mem.delete(kq[j]);
		kq = {};
		lpv_q = 1'b0; // Power-down closes the page
		rdat = fetch(a_q);
	end
endmodule : psc_mem_model
`default_nettype wire

/* verif/psc_ctrl_tb_top.sv */
// Self-checking bench for the pseudo-static RAM host controller
// Assumes the behavioural memory model on the far side of the pins
`timescale 1ns/1ns
`default_nettype none
module psc_ctrl_tb_top;
	import psc_pkg::*;
	logic clk_i = 0, arst_n_i = 0, clk_en_i = 1, req_valid_i = 0, prog_valid_i = 0, pd_req_i = 0;
	logic req_ready_o, rdata_valid_o, prog_ready_o, pd_active_o, busy_o;
	psc_req_t req_i = '0;
	psc_pd_mode_t prog_mode_i = PSC_PD_SLEEP;
	psc_pins_t pins_o, pv, pf;
	logic [15:0] rdata_o, dq_o, dq_i, d, d2;
	logic [1:0] dq_oe_o, m_oe;
	logic [21:0] a;
	logic [31:0] n;
	int err_count = 0, cmp_count = 0, seed = 2463, idl = 0;
	logic [31:0] exp_q [$]; // Notes: {mask, value}
	psc_pd_mode_t md [5] = '{PSC_PD_SLEEP, PSC_PD_SMALL, PSC_PD_MID, PSC_PD_LARGE, PSC_PD_SLEEP};
	logic [21:0] lm [5] = '{22'h00_0000, 22'h03_FFFF, 22'h07_FFFF, 22'h0F_FFFF, 22'h00_0000};
	always #5 clk_i = ~clk_i;
	// Host bus as the device sees it: undriven lanes show the inverse
	wire [15:0] hb = {dq_oe_o[1] ? dq_o[15:8] : ~dq_o[15:8], dq_oe_o[0] ? dq_o[7:0] : ~dq_o[7:0]};
	psc_ctrl u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_i(req_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
		.prog_valid_i(prog_valid_i), .prog_mode_i(prog_mode_i), .prog_ready_o(prog_ready_o), .pd_req_i(pd_req_i),
		.pd_active_o(pd_active_o), .busy_o(busy_o), .pins_o(pins_o), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
	psc_mem_model u_mem (.pins_i(pins_o), .dq_i(hb), .dq_o(dq_i), .dq_oe_o(m_oe));
	// ==========================================================
	// Checking
	// ==========================================================
	task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic results();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	// Oldest note against each read result
	always @(posedge clk_i) if (rdata_valid_o === 1'b1) begin
		n = exp_q.size() > 0 ? exp_q.pop_front() : 32'h0000_FFFF;
		chk("rdata", n[15:0], rdata_o & n[31:16]);
	end
	// Selected idle bound and address set up before strobes
	always @(posedge clk_i) begin
		idl = (!pins_o.chip_select_n && pins_o.write_en_n && pins_o.out_en_n) ? idl + 1 : 0;
		if (idl == IDLE_LIMIT_CYC) chk("selected idle", 16'h0000, 16'h0001);
		if (|(dq_oe_o & m_oe)) chk("bus clash", 16'h0000, {14'h0, dq_oe_o & m_oe});
		if (pv.out_en_n && pv.write_en_n && !(pins_o.out_en_n && pins_o.write_en_n))
			chk("addr setup", {pv.addr[15:0]}, pins_o.addr[15:0]);
		pv = pins_o;
	end
	// ==========================================================
	// Drivers
	// ==========================================================
	task automatic take(logic p);
		int k;
		k = 0;
		do begin
			@(negedge clk_i);
			k++;
		end while (((p ? prog_ready_o : req_ready_o) !== 1'b1) && k < 500);
		@(posedge clk_i);
		#1;
		req_valid_i = 0;
		prog_valid_i = 0;
		if (k >= 500) chk("taken", 16'h0001, 16'h0000);
	endtask : take
	task automatic acc(logic wr, logic [1:0] ln, logic [21:0] ad, logic [15:0] wd, logic [15:0] m);
		@(posedge clk_i);
		#1;
		req_i = '{write: wr, lane_en: ln, addr: ad, wdata: wd};
		req_valid_i = 1;
		if (!wr) exp_q.push_back({m, wd & m});
		take(1'b0);
	endtask : acc
	task automatic idle();
		int k;
		k = 0;
		do begin
			@(negedge clk_i);
			k++;
		end while ((busy_o !== 1'b0 || exp_q.size() != 0) && k < 500);
		if (k >= 500) chk("idle", 16'h0001, 16'h0000);
	endtask : idle
	// Power-down with a read held back until exit
	task automatic pdown(logic [21:0] ad, logic [15:0] e);
		idle();
		@(posedge clk_i);
		#1;
		pd_req_i = 1;
		req_i = '{write: 1'b0, lane_en: 2'b11, addr: ad, wdata: 16'h0000};
		req_valid_i = 1;
		repeat (20) @(posedge clk_i);
		#1;
		chk("pd state", 16'h0003, {14'h0, pd_active_o, pins_o.chip_select_n & ~pins_o.power_chip_select});
		chk("refused", 16'h0000, {15'h0, req_ready_o});
		pd_req_i = 0;
		exp_q.push_back({16'hFFFF, e});
		take(1'b0);
		idle();
	endtask : pdown
	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		repeat (16) @(posedge clk_i);
		#1;
		arst_n_i = 1;
		a = 22'(($random(seed)) & 32'h0000_0FF0);
		d = 16'($random(seed));
		d2 = 16'($random(seed));
		acc(1, 2'b11, a, d, 0);
		acc(1, 2'b01, a + 1, d2, 0);
		acc(1, 2'b10, a, ~d, 0);
		acc(0, 2'b11, a, {~d[15:8], d[7:0]}, 16'hFFFF);
		// Freeze mid-read; the strobe must outlast its access time
		@(posedge clk_i);
		#1;
		clk_en_i = 0;
		pf = pins_o;
		repeat (10) @(posedge clk_i);
		#1;
		chk("frozen pins", pf[27:12], pins_o[27:12]);
		clk_en_i = 1;
		acc(0, 2'b11, a + 1, {8'h5A, d2[7:0]}, 16'hFFFF);
		acc(0, 2'b01, a, d, 16'h00FF);
		acc(0, 2'b10, a, ~d, 16'hFF00);
		acc(0, 2'b00, a, 0, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			idle();
			if (i > 0) begin
				@(posedge clk_i);
				#1;
				prog_mode_i = md[i];
				prog_valid_i = 1;
				take(1'b1);
			end
			d = 16'($random(seed));
			acc(1, 2'b11, lm[i], d, 0); // written after programming when i > 0
			acc(1, 2'b11, lm[i] + 1, ~d, 0);
			pdown(lm[i], md[i] == PSC_PD_SLEEP ? 16'h5A5A : d);
			acc(0, 2'b11, lm[i] + 1, 16'h5A5A, 16'hFFFF);
		end
		idle();
		results();
	end
	initial begin
		#200_000;
		err_count++;
		results();
	end
endmodule : psc_ctrl_tb_top
`default_nettype wire
